/* File: shared/usb_ep1_pkg.sv */
// Constants for the endpoint 1 transmit and bus control logic.
// Assumes an 8-bit I/O register space and an 8-bit data memory bus.
package usb_ep1_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EP1_CFG_ADDR  = 8'h11;
  localparam logic [7:0] SCR_ADDR      = 8'h13;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] SCR_RESET     = 8'h00;
  localparam logic [4:0] SCR_USED_MASK = 5'h1f;
  // Endpoint 1 configuration fields
  localparam int CNT_LSB    = 0;
  localparam int CNT_MSB    = 3;
  localparam int EN_BIT     = 4;
  localparam int STALL_BIT  = 5;
  localparam int TOGGLE_BIT = 6;
  localparam int ARM_BIT    = 7;
  // Status and control fields
  localparam int ACT_BIT    = 0;
  localparam int K_BIT      = 1;
  localparam int J_BIT      = 2;
  localparam int AUTO_BIT   = 3;
  localparam int OUTEN_BIT  = 4;
  // ----------------------------------------------------------------
  // Endpoint 1 buffer in data memory
  // ----------------------------------------------------------------
  localparam logic [7:0] BUF_BASE  = 8'h78;
  localparam logic [7:0] BUF_LAST  = 8'h7f;
  localparam int         BUF_BYTES = 8;
  localparam logic [3:0] MAX_COUNT = 4'h8;
  // ----------------------------------------------------------------
  // Token and handshake codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} token_type;
  localparam logic [1:0] REPLY_ACK   = 2'h0;
  localparam logic [1:0] REPLY_NAK   = 2'h1;
  localparam logic [1:0] REPLY_STALL = 2'h2;
endpackage : usb_ep1_pkg

/* File: hw/usb_endpoint_one_transmit_config_and_bus_control.sv */
// Endpoint 1 transmit engine, its byte FIFO and the USB status/control.
// Assumes a packet layer that decodes tokens and data packets and
// serialises the outgoing data packet; all inputs share sys_clk.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      fill_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (fill_reg != (AW+1)'(DEPTH));
  assign out_valid = (fill_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg   <= '0;
    end else begin
      if (push) wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      if (pop)  rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      fill_reg <= (AW+1)'(fill_reg + push - pop);
    end
  end
endmodule : byte_fifo

module usb_endpoint_one_transmit_config_and_bus_control (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  // Core I/O register port
  input  wire logic [7:0]             io_addr,
  input  wire logic                   io_wr,
  input  wire logic [7:0]             io_wdata,
  output logic      [7:0]             io_rdata,
  // Core data memory writes
  input  wire logic [7:0]             dm_addr,
  input  wire logic                   dm_wr,
  input  wire logic [7:0]             dm_wdata,
  // Decoded tokens and received data packets
  input  wire logic                   tok_valid,
  input  wire usb_ep1_pkg::token_type tok_kind,
  input  wire logic [3:0]             tok_endp,
  input  wire logic                   rx_valid,
  input  wire logic                   rx_data1,
  input  wire logic [3:0]             rx_len,
  input  wire logic                   rx_err,
  input  wire logic                   hs_valid,
  input  wire logic                   hs_ack,
  // Handshake reply to the host
  output logic                        reply_valid,
  output logic      [1:0]             reply_code,
  output logic                        ep0_store,
  // Outgoing data packet
  output logic                        tx_start,
  output logic                        tx_data1,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output logic      [7:0]             tx_data,
  input  wire logic                   tx_done,
  // Line sense and forced drive
  input  wire logic                   line_dp,
  input  wire logic                   line_dm,
  output logic                        force_oe,
  output logic                        force_dp,
  output logic                        force_dm,
  // Endpoint 1 interrupt request
  output logic                        ep1_irq
);
  import usb_ep1_pkg::*;

  typedef enum {ST_IDLE, ST_LOAD, ST_SEND, ST_WAIT_HS} tx_state_type;

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0]   cfg_reg;
  logic [4:0]   scr_reg;
  logic [7:0]   buf_reg [BUF_BYTES];
  tx_state_type state_reg;
  tx_state_type state_next;
  logic [3:0]   ld_idx_reg;
  logic         out_pend_reg;
  logic         reply_valid_reg;
  logic [1:0]   reply_code_reg;
  logic         store_reg;
  logic         irq_reg;
  logic         start_reg;

  wire       cfg_wr    = io_wr && (io_addr == EP1_CFG_ADDR);
  wire       scr_wr    = io_wr && (io_addr == SCR_ADDR);
  wire       buf_wr    = dm_wr && (dm_addr >= BUF_BASE) &&
                         (dm_addr <= BUF_LAST);
  wire [2:0] buf_idx   = dm_addr[2:0];
  wire [3:0] raw_cnt   = cfg_reg[CNT_MSB:CNT_LSB];
  wire [3:0] send_cnt  = (raw_cnt > MAX_COUNT) ? MAX_COUNT : raw_cnt;
  wire       ep1_en    = cfg_reg[EN_BIT];
  wire       ep1_stall = cfg_reg[STALL_BIT];
  wire       ep1_arm   = cfg_reg[ARM_BIT];
  wire       auto_out  = scr_reg[AUTO_BIT];
  wire       out_en    = scr_reg[OUTEN_BIT];

  wire tok_ep1   = tok_valid && (tok_endp == 4'h1) && ep1_en;
  wire tok_ep0   = tok_valid && (tok_endp == 4'h0);
  wire ep1_in    = tok_ep1 && (tok_kind == TOK_IN);
  wire ep1_out   = tok_ep1 && (tok_kind == TOK_OUT);
  wire stall_ep1 = (ep1_in || ep1_out) && ep1_stall;
  wire send_go   = ep1_in && !ep1_stall && ep1_arm &&
                   (state_reg == ST_IDLE);
  wire nak_ep1   = ep1_in && !ep1_stall && !ep1_arm;
  wire setup0    = tok_ep0 && (tok_kind == TOK_SETUP);
  wire rx_ep0    = rx_valid && out_pend_reg && !rx_err;
  wire stat_ok   = rx_data1 && (rx_len == 4'h0);
  wire auto_ack  = rx_ep0 && auto_out && stat_ok;
  wire auto_stl  = rx_ep0 && auto_out && !stat_ok;
  wire out_ack   = rx_ep0 && !auto_out && out_en;
  wire out_nak   = rx_ep0 && !auto_out && !out_en;
  wire host_ack  = (state_reg == ST_WAIT_HS) && hs_valid && hs_ack;
  wire line_busy = !(!line_dp && line_dm);

  // ----------------------------------------------------------------
  // Endpoint 1 configuration
  // ----------------------------------------------------------------
  logic [7:0] cfg_next;
  always_comb begin
    cfg_next = cfg_wr ? io_wdata : cfg_reg;
    if (host_ack && !cfg_wr) cfg_next[ARM_BIT] = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Status and control
  // ----------------------------------------------------------------
  logic [4:0] scr_next;
  always_comb begin
    scr_next = scr_reg;
    if (scr_wr) begin
      scr_next = io_wdata[4:0] & SCR_USED_MASK;
      scr_next[ACT_BIT] = scr_reg[ACT_BIT] & io_wdata[ACT_BIT];
    end
    if (line_busy) scr_next[ACT_BIT] = 1'b1;
    if (setup0) begin
      scr_next[AUTO_BIT]  = 1'b0;
      scr_next[OUTEN_BIT] = 1'b0;
    end
    if (out_ack) scr_next[OUTEN_BIT] = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scr_reg <= SCR_RESET[4:0];
    end else begin
      scr_reg <= scr_next;
    end
  end

  assign io_rdata = (io_addr == EP1_CFG_ADDR) ? cfg_reg :
                    (io_addr == SCR_ADDR)     ? {3'h0, scr_reg} : 8'h00;

  // K wins when firmware sets both forcing bits
  assign force_oe = scr_reg[K_BIT] || scr_reg[J_BIT];
  assign force_dp = scr_reg[K_BIT];
  assign force_dm = !scr_reg[K_BIT] && scr_reg[J_BIT];

  // ----------------------------------------------------------------
  // Endpoint 1 buffer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (buf_wr) buf_reg[buf_idx] <= dm_wdata;
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  wire  ld_more = (ld_idx_reg < send_cnt);
  wire  push    = (state_reg == ST_LOAD) && ld_more;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:    if (send_go) state_next = ST_LOAD;
      ST_LOAD:    if (!ld_more) state_next = ST_SEND;
      ST_SEND:    if (tx_done) state_next = ST_WAIT_HS;
      ST_WAIT_HS: if (hs_valid || tok_valid) state_next = ST_IDLE;
      default:    state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= ST_IDLE;
      ld_idx_reg <= 4'h0;
      start_reg  <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      start_reg  <= send_go;
      irq_reg    <= host_ack;
      if (send_go) begin
        ld_idx_reg <= 4'h0;
      end else if (push && fifo_in_ready) begin
        ld_idx_reg <= 4'(ld_idx_reg + 1'b1);
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(BUF_BYTES)) tx_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (buf_reg[ld_idx_reg[2:0]]),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  assign tx_start = start_reg;
  assign tx_data1 = cfg_reg[TOGGLE_BIT];
  assign ep1_irq  = irq_reg;

  // ----------------------------------------------------------------
  // Handshake replies and endpoint 0 OUT handling
  // ----------------------------------------------------------------
  wire       rep_any  = stall_ep1 || nak_ep1 || auto_ack || auto_stl ||
                        out_ack || out_nak;
  wire [1:0] rep_code = (stall_ep1 || auto_stl)  ? REPLY_STALL :
                        (nak_ep1 || out_nak)     ? REPLY_NAK : REPLY_ACK;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_pend_reg    <= 1'b0;
      reply_valid_reg <= 1'b0;
      reply_code_reg  <= REPLY_ACK;
      store_reg       <= 1'b0;
    end else begin
      if (tok_valid) out_pend_reg <= tok_ep0 && (tok_kind == TOK_OUT);
      else if (rx_valid) out_pend_reg <= 1'b0;
      reply_valid_reg <= rep_any;
      reply_code_reg  <= rep_code;
      store_reg       <= out_ack;
    end
  end

  assign reply_valid = reply_valid_reg;
  assign reply_code  = reply_code_reg;
  assign ep0_store   = store_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  arm_clear_irq_a: assert property (host_ack && !cfg_wr |=>
    !ep1_arm && ep1_irq) else $error("arm not cleared on ack");
  disabled_ignore_a: assert property (tok_valid && tok_endp == 4'h1 &&
    !ep1_en |=> !reply_valid && !tx_start)
    else $error("disabled endpoint answered");
  stall_reply_a: assert property (stall_ep1 |=>
    reply_valid && reply_code == REPLY_STALL) else $error("stall not sent");
  nak_unarmed_a: assert property (nak_ep1 |=>
    reply_valid && reply_code == REPLY_NAK) else $error("unarmed IN not NAKed");
  send_armed_a: assert property ($rose(tx_start) |->
    $past(ep1_arm) && $past(ep1_en)) else $error("send without arm");
  activity_set_a: assert property (line_busy |=> scr_reg[ACT_BIT])
    else $error("activity not flagged");
  activity_keep_a: assert property (scr_wr && io_wdata[ACT_BIT] &&
    !line_busy |=> scr_reg[ACT_BIT] == $past(scr_reg[ACT_BIT]))
    else $error("activity changed by 1");
  resume_k_a: assert property (scr_reg[K_BIT] |->
    force_oe && force_dp && !force_dm) else $error("K not driven");
  setup_clear_a: assert property (setup0 |=>
    !auto_out && !out_en) else $error("setup left bits");
  status_ack_a: assert property (auto_ack |=> reply_valid &&
    reply_code == REPLY_ACK && !ep0_store)
    else $error("status OUT mishandled");
  nak_keep_a: assert property (out_nak |=> reply_valid &&
    reply_code == REPLY_NAK && !ep0_store) else $error("OUT NAK wrong");
  load_count_a: assert property (state_reg == ST_LOAD && !ld_more |->
    ld_idx_reg == send_cnt) else $error("load count wrong");
  full_send_c: cover property (send_go ##[1:60] host_ack);
  status_out_c: cover property (auto_ack);
  resume_c: cover property (scr_reg[J_BIT] ##1 scr_reg[K_BIT]);
endmodule : usb_endpoint_one_transmit_config_and_bus_control

`default_nettype wire

/* File: verification/usb_host_model.sv */
// Host side model: tokens, data packets, handshakes and the serializer
// that drains endpoint 1 data with random stalls.
// Assumes it shares sys_clk with the engine; the bench resolves the line.
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  // Clock
  input  wire logic              sys_clk,
  // Token and packet side
  output logic                   tok_valid,
  output usb_ep1_pkg::token_type tok_kind,
  output logic [3:0]             tok_endp,
  output logic                   rx_valid,
  output logic                   rx_data1,
  output logic [3:0]             rx_len,
  output logic                   rx_err,
  output logic                   hs_valid,
  output logic                   hs_ack,
  // Serializer side
  input  wire logic              tx_start,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic                   tx_done,
  // Host drive of the line, idle is J
  output logic                   host_dp,
  output logic                   host_dm
);
  import usb_ep1_pkg::*;

  initial begin
    {tok_valid, tok_endp, rx_valid, rx_data1, rx_len, rx_err} = '0;
    {hs_valid, hs_ack, tx_ready, tx_done, host_dp} = '0;
    tok_kind = TOK_OUT;
    host_dm  = 1'b1;
  end

  // Serializer stalls about one cycle in four
  always @(posedge sys_clk) begin
    tx_ready <= ($urandom % 4) != 0;
  end

  // Released qualifiers other than tok_kind and hs_ack show the inverse of their last value
  task automatic token(input token_type k, input logic [3:0] ep);
    @(posedge sys_clk);
    tok_valid <= 1'b1;
    tok_kind  <= k;
    tok_endp  <= ep;
    @(posedge sys_clk);
    tok_valid <= 1'b0;
    tok_endp  <= ~ep;
  endtask : token

  task automatic packet(input logic d1, input logic [3:0] len,
                        input logic err);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data1 <= d1;
    rx_len   <= len;
    rx_err   <= err;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data1 <= ~d1;
    rx_len   <= ~len;
    rx_err   <= ~err;
  endtask : packet

  // Drain n bytes, report the packet sent, then answer ACK or not
  task automatic send_in(input int n, input logic ack);
    int got;
    got = 0;
    repeat (20) begin
      @(posedge sys_clk);
      if (tx_start) break;
    end
    repeat (200) begin
      if (got >= n) break;
      @(posedge sys_clk);
      if (tx_valid && tx_ready) got++;
    end
    repeat (3) @(posedge sys_clk);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    hs_valid <= 1'b1;
    hs_ack   <= ack;
    @(posedge sys_clk);
    hs_valid <= 1'b0;
    hs_ack   <= 1'b0;
  endtask : send_in

  task automatic se0_pulse();
    @(posedge sys_clk);
    host_dm <= 1'b0;
    @(posedge sys_clk);
    host_dm <= 1'b1;
  endtask : se0_pulse
endmodule : usb_host_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the endpoint 1 transmit and bus control engine.
// Assumes usb_host_model on the packet side; the bench acts as firmware.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import usb_ep1_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       sys_clk, arst_n, io_wr, dm_wr;
  logic [7:0] io_addr, io_wdata, io_rdata, dm_addr, dm_wdata, tx_data;
  logic       tok_valid, rx_valid, rx_data1, rx_err, hs_valid, hs_ack;
  token_type  tok_kind;
  logic [3:0] tok_endp, rx_len;
  logic [1:0] reply_code;
  logic       reply_valid, ep0_store, tx_start, tx_data1, tx_valid;
  logic       tx_ready, tx_done, line_dp, line_dm, host_dp, host_dm;
  logic       force_oe, force_dp, force_dm, ep1_irq;
  logic [7:0] q_evt[$], q_byte[$], q_tog[$], buf_b[8], cfg;
  int         err_count, n_tests;

  usb_endpoint_one_transmit_config_and_bus_control DUT (.sys_clk, .arst_n, .io_addr, .io_wr,
    .io_wdata, .io_rdata, .dm_addr, .dm_wr, .dm_wdata, .tok_valid,
    .tok_kind, .tok_endp, .rx_valid, .rx_data1, .rx_len, .rx_err,
    .hs_valid, .hs_ack, .reply_valid, .reply_code, .ep0_store, .tx_start,
    .tx_data1, .tx_valid, .tx_ready, .tx_data, .tx_done, .line_dp,
    .line_dm, .force_oe, .force_dp, .force_dm, .ep1_irq);
  usb_host_model host (.sys_clk, .tok_valid, .tok_kind, .tok_endp,
    .rx_valid, .rx_data1, .rx_len, .rx_err, .hs_valid, .hs_ack, .tx_start,
    .tx_valid, .tx_ready, .tx_done, .host_dp, .host_dm);

  // Forced drive overrides the host on the shared line
  assign line_dp = force_oe ? force_dp : host_dp;
  assign line_dm = force_oe ? force_dm : host_dm;

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] pop(ref logic [7:0] q[$]);
    pop = (q.size() != 0) ? q.pop_front() : 8'hee;
  endfunction : pop

  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr <= 1'b0;
  endtask : io_write

  task automatic io_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    io_addr <= a;
    @(posedge sys_clk);
    #1 check(io_rdata, exp);
  endtask : io_read

  task automatic dm_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    dm_addr  <= a;
    dm_wdata <= d;
    dm_wr    <= 1'b1;
    @(posedge sys_clk);
    dm_wr <= 1'b0;
  endtask : dm_write

  task automatic out0(input logic d1, input logic [3:0] len);
    host.token(TOK_OUT, 4'h0);
    host.packet(d1, len, 1'b0);
    repeat (3) @(posedge sys_clk);
  endtask : out0

  task automatic results();
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Event code: irq, store, reply code
  always @(posedge sys_clk) begin
    if (arst_n && (reply_valid || ep0_store || ep1_irq))
      check({4'h0, ep1_irq, ep0_store, reply_valid ? reply_code : 2'b00},
            pop(q_evt));
    if (arst_n && tx_start) check({7'h0, tx_data1}, pop(q_tog));
    if (arst_n && tx_valid && tx_ready) check(tx_data, pop(q_byte));
  end

  initial begin
    #(1_000_000);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    arst_n  = 1'b0;
    {io_wr, dm_wr, io_addr, io_wdata, dm_addr, dm_wdata} = '0;
    err_count = 0;
    n_tests   = 0;
    void'($urandom(32'h3491));
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    io_read(EP1_CFG_ADDR, CFG_RESET);
    io_read(SCR_ADDR, SCR_RESET);
    io_read(8'h12, 8'h00);
    cfg = {1'b0, 3'($urandom), 4'($urandom % 9)};
    io_write(EP1_CFG_ADDR, cfg);
    io_read(EP1_CFG_ADDR, cfg);
    io_write(EP1_CFG_ADDR, 8'h83);
    host.token(TOK_IN, 4'h1);
    host.token(TOK_OUT, 4'h1);
    q_evt.push_back({6'h0, REPLY_NAK});
    io_write(EP1_CFG_ADDR, 8'h13);
    host.token(TOK_IN, 4'h1);
    q_evt.push_back({6'h0, REPLY_STALL});
    q_evt.push_back({6'h0, REPLY_STALL});
    io_write(EP1_CFG_ADDR, 8'hb3);
    host.token(TOK_IN, 4'h1);
    host.token(TOK_OUT, 4'h1);
    repeat (4) @(posedge sys_clk);
    for (int n = 0; n <= 8; n++) begin
      foreach (buf_b[i]) begin
        buf_b[i] = 8'($urandom);
        dm_write(BUF_BASE + 8'(i), buf_b[i]);
      end
      dm_write(BUF_BASE - 8'h01, ~buf_b[0]);
      dm_write(BUF_LAST + 8'h01, ~buf_b[7]);
      for (int i = 0; i < n; i++) q_byte.push_back(buf_b[i]);
      q_tog.push_back({7'h0, n[0]});
      if (n != 4) q_evt.push_back(8'h08);
      cfg = {1'b1, n[0], 2'b01, 4'(n)};
      io_write(EP1_CFG_ADDR, cfg);
      host.token(TOK_IN, 4'h1);
      host.send_in(n, n != 4);
      repeat (3) @(posedge sys_clk);
      io_read(EP1_CFG_ADDR, (n != 4) ? cfg & 8'h7f : cfg);
    end
    io_write(SCR_ADDR, 8'h18);
    io_read(SCR_ADDR, 8'h18);
    host.token(TOK_SETUP, 4'h0);
    io_read(SCR_ADDR, 8'h00);
    q_evt.push_back({5'h0, 1'b1, REPLY_ACK});
    q_evt.push_back({6'h0, REPLY_NAK});
    io_write(SCR_ADDR, 8'h10);
    out0(1'b0, 4'h3);
    io_read(SCR_ADDR, 8'h00);
    out0(1'b1, 4'h2);
    io_write(SCR_ADDR, 8'h10);
    host.token(TOK_OUT, 4'h0);
    host.packet(1'b0, 4'h2, 1'b1);
    repeat (3) @(posedge sys_clk);
    io_read(SCR_ADDR, 8'h10);
    q_evt.push_back({6'h0, REPLY_ACK});
    q_evt.push_back({6'h0, REPLY_STALL});
    q_evt.push_back({6'h0, REPLY_STALL});
    io_write(SCR_ADDR, 8'h18);
    out0(1'b1, 4'h0);
    out0(1'b0, 4'h0);
    out0(1'b1, 4'h4);
    io_read(SCR_ADDR, 8'h18);
    io_write(SCR_ADDR, 8'h00);
    host.se0_pulse();
    repeat (2) @(posedge sys_clk);
    io_read(SCR_ADDR, 8'h01);
    io_write(SCR_ADDR, 8'h01);
    io_read(SCR_ADDR, 8'h01);
    io_write(SCR_ADDR, 8'h00);
    io_read(SCR_ADDR, 8'h00);
    io_write(SCR_ADDR, 8'h01);
    io_read(SCR_ADDR, 8'h00);
    io_write(SCR_ADDR, 8'h04);
    #1 check({5'h0, force_oe, force_dp, force_dm}, 8'h05);
    repeat (2) @(posedge sys_clk);
    io_read(SCR_ADDR, 8'h04);
    io_write(SCR_ADDR, 8'h06);
    #1 check({5'h0, force_oe, force_dp, force_dm}, 8'h06);
    repeat (2) @(posedge sys_clk);
    io_read(SCR_ADDR, 8'h07);
    io_write(SCR_ADDR, 8'h00);
    repeat (3) @(posedge sys_clk);
    io_write(SCR_ADDR, 8'h00);
    #1 check({5'h0, force_oe, force_dp, force_dm}, 8'h00);
    io_read(SCR_ADDR, 8'h00);
    check(8'(q_evt.size() + q_byte.size() + q_tog.size()), 8'h00);
    results();
  end
endmodule : tb
`default_nettype wire
